// file: logic/adcri_top.sv
// Register interface of a 12-bit converter: APB slave, start handshake, result formatting.
// Assumes a converter core that returns a value with a done pulse, and pin-sharing outside.
// Function
// RULE_01: Format 0: high byte D11..4, low D3..0 upper
// RULE_02: Format 1: high nibble D11..8, low byte D7..0
// RULE_03: Unused result bit positions read zero
// RULE_04: Disabled converter keeps result and limits unchanged
// RULE_05: Start after start bit goes high then low
// RULE_06: Start sequence sets busy flag
// RULE_07: Busy clears at completion; writes ignored
// RULE_08: Enable low powers converter down
// RULE_09: Channel codes 0..8 route analog pins 0..8
// RULE_10: Codes 9, 10 reserved; 11..15 float
// RULE_11: Analog-assigned pin loses digital function, pull-high
// RULE_12: Two limit pairs follow result format
// RULE_13: One converter; source and channel select input
// RULE_14: Delay register used only on delayed path
// RULE_15: Internal source disconnects external channel
// RULE_16: Delay counts clocks from PWM flag rise
// RULE_17: Trigger select: 0 start bit, 1 delayed
// RULE_18: Result updates as busy clears
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

`include "adcri_consts.svh"

module adcri_top
	import adcri_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Converter core
	output adcri_core_req_t core_req,
	input wire adcri_core_rsp_t core_rsp,
	// PWM match flags for delayed start
	input wire logic pwm_period_match_flag,
	input wire logic pwm_duty_match_flag,
	// Pin sharing: pins routed as analog inputs
	input wire logic [8:0] analog_pin_assign,
	output logic [8:0] analog_input_pins,
	output logic ext_floating,
	// Interrupt
	output logic irq
);

	adcri_state_t s;
	adcri_state_t next_s;

	// High byte of a 12-bit value in the chosen format
	function automatic logic [7:0] fmt_hi(input logic [11:0] v, input logic fmt);
		fmt_hi = fmt ? {4'h0, v[11:8]} : v[11:4];
	endfunction

	// Low byte of a 12-bit value in the chosen format
	function automatic logic [7:0] fmt_lo(input logic [11:0] v, input logic fmt);
		fmt_lo = fmt ? v[7:0] : {v[3:0], 4'h0};
	endfunction

	// Merge a written high byte into a 12-bit value
	function automatic logic [11:0] put_hi(input logic [11:0] v, input logic [7:0] b,
		input logic fmt);
		put_hi = fmt ? {b[3:0], v[7:0]} : {b, v[3:0]};
	endfunction

	// Merge a written low byte into a 12-bit value
	function automatic logic [11:0] put_lo(input logic [11:0] v, input logic [7:0] b,
		input logic fmt);
		put_lo = fmt ? {v[11:8], b} : {v[11:4], b[7:4]};
	endfunction

	logic acc;
	logic wr;
	logic fmt;
	logic en;
	logic pwm_sel;
	logic [7:0] wb;
	logic [7:0] rbyte;
	logic hit;
	logic trig_start;
	logic trig_delay;
	logic [1:0] ev;

	// Access phase decode; one wait state, then pready for a single cycle.
	// A write commits only at the edge where the master sees pready high,
	// so the wait-state cycle applies nothing; an access phase held on past pready repeats the write every second cycle.
	assign acc = psel & penable;
	assign wr = acc & s.pready & pwrite & pstrb[0];
	assign wb = pwdata[7:0];
	assign fmt = s.conversion_control[`ADCRI_CTRL_FMT];
	assign en = s.conversion_control[`ADCRI_CTRL_EN];
	assign pwm_sel = s.trigger_compare_control[`ADCRI_TRIG_PWIS] ? pwm_duty_match_flag
		: pwm_period_match_flag;

	// Read mux
	always_comb begin
		hit = 1'b1;
		rbyte = 8'h00;
		case (paddr)
			`ADCRI_OFF_RES_LO: rbyte = fmt_lo(s.result, fmt); // [RULE_01] [RULE_02] [RULE_03]
			`ADCRI_OFF_RES_HI: rbyte = fmt_hi(s.result, fmt); // [RULE_01] [RULE_02] [RULE_03]
			`ADCRI_OFF_LLIM_LO: rbyte = fmt_lo(s.lower_limit, fmt); // [RULE_12]
			`ADCRI_OFF_LLIM_HI: rbyte = fmt_hi(s.lower_limit, fmt); // [RULE_12]
			`ADCRI_OFF_ULIM_LO: rbyte = fmt_lo(s.upper_limit, fmt); // [RULE_12]
			`ADCRI_OFF_ULIM_HI: rbyte = fmt_hi(s.upper_limit, fmt); // [RULE_12]
			`ADCRI_OFF_CTRL: rbyte = s.conversion_control;
			`ADCRI_OFF_SRC: rbyte = s.source_clock_select;
			`ADCRI_OFF_REF: rbyte = s.reference_gain_select;
			`ADCRI_OFF_TRIG: rbyte = s.trigger_compare_control;
			`ADCRI_OFF_DELAY: rbyte = s.start_delay_count;
			`ADCRI_OFF_BGAP: rbyte = s.bandgap_enable_control;
			`ADCRI_OFF_IRQ_STAT: rbyte = {6'h00, s.irq_status};
			`ADCRI_OFF_IRQ_CLR: rbyte = 8'h00;
			`ADCRI_OFF_IRQ_EN: rbyte = {6'h00, s.irq_enable};
			default: hit = 1'b0;
		endcase
	end

	// Start triggers: falling write of the start bit, or delayed path
	assign trig_start = wr && paddr == `ADCRI_OFF_CTRL && s.conversion_control[`ADCRI_CTRL_START]
		&& !wb[`ADCRI_CTRL_START] && !s.trigger_compare_control[`ADCRI_TRIG_PATH]; // [RULE_05] [RULE_17]
	assign trig_delay = s.phase == ADCRI_DELAY && s.count == 8'h00;

	// Next state
	always_comb begin
		next_s = s;
		ev = 2'b00;
		// Answer once per transfer: the first access cycle raises pready
		next_s.pready = acc & ~s.pready;
		next_s.pslverr = acc & ~s.pready & ~hit;
		next_s.prdata = (acc & ~s.pready & ~pwrite & hit) ? {24'h000000, rbyte} : 32'h00000000;
		next_s.pwm_prev = pwm_sel;
		// Register writes; unmapped offsets and lane 0 cleared are dropped
		if (wr && hit) begin
			case (paddr)
				`ADCRI_OFF_LLIM_LO: if (en) next_s.lower_limit = put_lo(s.lower_limit, wb, fmt); // [RULE_04]
				`ADCRI_OFF_LLIM_HI: if (en) next_s.lower_limit = put_hi(s.lower_limit, wb, fmt); // [RULE_04]
				`ADCRI_OFF_ULIM_LO: if (en) next_s.upper_limit = put_lo(s.upper_limit, wb, fmt); // [RULE_04]
				`ADCRI_OFF_ULIM_HI: if (en) next_s.upper_limit = put_hi(s.upper_limit, wb, fmt); // [RULE_04]
				`ADCRI_OFF_CTRL: begin
					// Busy bit keeps its own value
					next_s.conversion_control = {wb[7], s.conversion_control[`ADCRI_CTRL_BUSY],
						wb[5:0]}; // [RULE_07]
				end
				`ADCRI_OFF_SRC: next_s.source_clock_select = wb & `ADCRI_SRC_MASK;
				`ADCRI_OFF_REF: next_s.reference_gain_select = wb & `ADCRI_REF_MASK;
				`ADCRI_OFF_TRIG: next_s.trigger_compare_control = wb & `ADCRI_TRIG_MASK;
				`ADCRI_OFF_DELAY: next_s.start_delay_count = wb; // [RULE_14]
				`ADCRI_OFF_BGAP: next_s.bandgap_enable_control = wb & `ADCRI_BGAP_MASK;
				`ADCRI_OFF_IRQ_EN: next_s.irq_enable = wb[1:0];
				default: ;
			endcase
		end
		// Conversion sequencer
		case (s.phase)
			ADCRI_IDLE: begin
				if (en && trig_start) begin
					next_s.phase = ADCRI_CONV;
					next_s.count = 8'(`ADCRI_CONV_CYC - 1);
					next_s.conversion_control[`ADCRI_CTRL_BUSY] = 1'b1; // [RULE_06]
				end else if (en && s.trigger_compare_control[`ADCRI_TRIG_PATH]
					&& s.trigger_compare_control[`ADCRI_TRIG_DLEN]
					&& pwm_sel && !s.pwm_prev) begin
					// Delay counts system clocks from the flag's rise
					next_s.phase = ADCRI_DELAY; // [RULE_16] [RULE_17] [RULE_14]
					next_s.count = s.start_delay_count - 8'h01;
				end
			end
			ADCRI_DELAY: begin
				next_s.count = s.count - 8'h01; // [RULE_16]
				if (!en) begin
					next_s.phase = ADCRI_IDLE;
				end else if (trig_delay) begin
					next_s.phase = ADCRI_CONV;
					next_s.count = 8'(`ADCRI_CONV_CYC - 1);
					next_s.conversion_control[`ADCRI_CTRL_BUSY] = 1'b1; // [RULE_06]
				end
			end
			ADCRI_CONV: begin
				if (!en) begin
					// Conversion abandoned, result untouched
					next_s.phase = ADCRI_IDLE;
					next_s.conversion_control[`ADCRI_CTRL_BUSY] = 1'b0; // [RULE_04]
				end else if (core_rsp.done) begin
					next_s.phase = ADCRI_IDLE;
					next_s.result = core_rsp.value; // [RULE_18]
					next_s.conversion_control[`ADCRI_CTRL_BUSY] = 1'b0; // [RULE_07] [RULE_18]
					ev[`ADCRI_IRQ_DONE] = 1'b1;
					if (core_rsp.value <= s.lower_limit || core_rsp.value >= s.upper_limit) begin
						ev[`ADCRI_IRQ_BOUND] = 1'b1; // [RULE_12]
					end
				end
			end
			default: next_s.phase = ADCRI_IDLE;
		endcase
		// Sticky status; a new event wins over a clear
		if (wr && paddr == `ADCRI_OFF_IRQ_CLR) begin
			next_s.irq_status = s.irq_status & ~wb[1:0];
		end
		next_s.irq_status = next_s.irq_status | ev;
		next_s.irq = |(next_s.irq_status & next_s.irq_enable);
		// Core request and input routing
		next_s.core.power_on = next_s.conversion_control[`ADCRI_CTRL_EN]; // [RULE_08]
		next_s.core.sample = next_s.phase == ADCRI_CONV && s.phase != ADCRI_CONV;
		next_s.core.ext_channel_select = next_s.conversion_control[3:0]; // [RULE_13]
		next_s.core.input_source_select = next_s.source_clock_select[7:5]; // [RULE_13]
		next_s.pin_analog = 9'h000;
		next_s.ext_floating = 1'b0;
		if (next_s.source_clock_select[7:5] == 3'h0 && next_s.conversion_control[`ADCRI_CTRL_EN]) begin
			if (next_s.conversion_control[3:0] <= `ADCRI_CH_MAX) begin
				next_s.pin_analog[next_s.conversion_control[3:0]] = 1'b1; // [RULE_09]
			end else begin
				next_s.ext_floating = 1'b1; // [RULE_10]
			end
		end // [RULE_15]
		// Pins handed over as analog drop digital function and pull-high
		next_s.pin_analog = next_s.pin_analog & analog_pin_assign; // [RULE_11]
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from flip-flops
	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign irq = s.irq;
	assign core_req = s.core;
	assign analog_input_pins = s.pin_analog;
	assign ext_floating = s.ext_floating;

	// Busy set after start sequence
	sequence start_seq;
		trig_start && en && s.phase == ADCRI_IDLE;
	endsequence

	chk_busy_on_start: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_05]
		start_seq |=> s.conversion_control[`ADCRI_CTRL_BUSY]) else $error("busy not set");
	chk_busy_no_start: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_06]
		$rose(s.conversion_control[`ADCRI_CTRL_BUSY]) |-> core_req.sample)
		else $error("busy rose without start");
	chk_busy_clear: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_07]
		(s.phase == ADCRI_CONV && en && core_rsp.done) |=>
		!s.conversion_control[`ADCRI_CTRL_BUSY]) else $error("busy not cleared");
	chk_result_update: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_18]
		(s.phase == ADCRI_CONV && en && core_rsp.done) |=> s.result == $past(core_rsp.value))
		else $error("result not updated");
	chk_result_hold: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_04]
		!en |=> $stable(s.result) && $stable(s.lower_limit) && $stable(s.upper_limit))
		else $error("data changed while disabled");
	chk_fmt_zero: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_03]
		(acc && !pwrite && paddr == `ADCRI_OFF_RES_HI && fmt) |=> prdata[7:4] == 4'h0)
		else $error("unused bits not zero");
	chk_fmt_left: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_01]
		(acc && !pwrite && paddr == `ADCRI_OFF_RES_LO && !fmt) |=> prdata[3:0] == 4'h0)
		else $error("low nibble not zero");
	chk_internal_src: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_15]
		s.core.input_source_select != 3'h0 |-> analog_input_pins == 9'h000)
		else $error("pin routed with internal source");
	chk_power_off: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_08]
		!en |-> !core_req.power_on) else $error("core powered while disabled");
	chk_float_code: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_10]
		(s.core.ext_channel_select >= `ADCRI_CH_FLOAT) |-> analog_input_pins == 9'h000)
		else $error("floating code routed a pin");

	// APB answer: one wait state, then a single-cycle pready
	chk_pready_answer: assert property (@(posedge pclk) disable iff (!presetn)
		(acc && !pready) |=> pready) else $error("pready missing after access");
	chk_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready) else $error("pready held past one cycle");
	chk_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
		(acc && !pready && !hit) |=> pslverr && prdata == 32'h00000000)
		else $error("unmapped access not refused");
	chk_prdata_idle: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_03]
		!pready |-> prdata == 32'h00000000) else $error("read data outside answer");

	// Lane 0 strobe gates every write
	chk_strobe_ignore: assert property (@(posedge pclk) disable iff (!presetn)
		(acc && pready && pwrite && !pstrb[0] && paddr == `ADCRI_OFF_DELAY) |=>
		$stable(s.start_delay_count)) else $error("write without lane strobe");

	// First access cycle of a result read, with no result update pending
	sequence res_rd_hi;
		acc && !pwrite && !pready && paddr == `ADCRI_OFF_RES_HI && s.phase != ADCRI_CONV;
	endsequence
	sequence res_rd_lo;
		acc && !pwrite && !pready && paddr == `ADCRI_OFF_RES_LO && s.phase != ADCRI_CONV;
	endsequence

	// Byte layout of the result in both formats
	chk_fmt_left_hi: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_01]
		res_rd_hi ##0 !fmt |=> prdata[7:0] == s.result[11:4])
		else $error("high byte wrong in format 0");
	chk_fmt_right_hi: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_02]
		res_rd_hi ##0 fmt |=> prdata[7:0] == {4'h0, s.result[11:8]})
		else $error("high byte wrong in format 1");
	chk_fmt_right_lo: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_02]
		res_rd_lo ##0 fmt |=> prdata[7:0] == s.result[7:0])
		else $error("low byte wrong in format 1");

	// Limit bytes land where the format puts them
	chk_limit_write: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_12]
		(wr && hit && en && !fmt && paddr == `ADCRI_OFF_LLIM_HI) |=>
		s.lower_limit[11:4] == $past(wb)) else $error("limit byte misplaced");

	// Busy mirrors the converting phase; software writes cannot move it
	chk_busy_phase: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_07]
		s.conversion_control[`ADCRI_CTRL_BUSY] == (s.phase == ADCRI_CONV))
		else $error("busy flag out of step");
	chk_abort_idle: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_04]
		(s.phase == ADCRI_CONV && !en) |=> s.phase == ADCRI_IDLE && $stable(s.result))
		else $error("abort did not return to idle");
	chk_sample_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		core_req.sample |=> !core_req.sample) else $error("sample held past one cycle");

	// Delayed start: load on the flag rise, convert when the count runs out
	sequence pwm_rise;
		s.phase == ADCRI_IDLE && en && s.trigger_compare_control[`ADCRI_TRIG_PATH]
			&& s.trigger_compare_control[`ADCRI_TRIG_DLEN] && pwm_sel && !s.pwm_prev;
	endsequence
	sequence delay_done;
		s.phase == ADCRI_DELAY && en && s.count == 8'h00;
	endsequence
	chk_delay_load: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_16]
		pwm_rise |=> s.phase == ADCRI_DELAY && s.count == $past(s.start_delay_count) - 8'h01)
		else $error("delay not loaded");
	chk_delay_fire: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_16]
		delay_done |=> s.phase == ADCRI_CONV && core_req.sample)
		else $error("delay end did not start");
	chk_start_path: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_17]
		(s.phase == ADCRI_IDLE && s.trigger_compare_control[`ADCRI_TRIG_PATH]) |=>
		s.phase != ADCRI_CONV) else $error("start bit used on delayed path");

	// External routing: only the selected pin may be handed to the converter
	chk_ext_route: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_09]
		(s.core.input_source_select == 3'h0 && s.core.ext_channel_select <= `ADCRI_CH_MAX)
		|-> !ext_floating && (analog_input_pins & ~(9'h001 << s.core.ext_channel_select))
		== 9'h000) else $error("wrong pin routed");

	// Status bits stay set until software clears them
	chk_status_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		(s.irq_status[`ADCRI_IRQ_DONE] && !(wr && paddr == `ADCRI_OFF_IRQ_CLR)) |=>
		s.irq_status[`ADCRI_IRQ_DONE]) else $error("status bit lost");

endmodule

// file: logic/adcri_consts.svh
// Offsets, field positions, reset values and timing counts of the converter register block.
// Assumes inclusion by bare name from the package and the design module.
`ifndef ADCRI_CONSTS_SVH
`define ADCRI_CONSTS_SVH

// Register byte addresses, one aligned word each
`define ADCRI_OFF_RES_LO 12'h000
`define ADCRI_OFF_RES_HI 12'h004
`define ADCRI_OFF_LLIM_LO 12'h008
`define ADCRI_OFF_LLIM_HI 12'h00c
`define ADCRI_OFF_ULIM_LO 12'h010
`define ADCRI_OFF_ULIM_HI 12'h014
`define ADCRI_OFF_CTRL 12'h018
`define ADCRI_OFF_SRC 12'h01c
`define ADCRI_OFF_REF 12'h020
`define ADCRI_OFF_TRIG 12'h024
`define ADCRI_OFF_DELAY 12'h028
`define ADCRI_OFF_BGAP 12'h02c
`define ADCRI_OFF_IRQ_STAT 12'h030
`define ADCRI_OFF_IRQ_CLR 12'h034
`define ADCRI_OFF_IRQ_EN 12'h038

// Control register fields
`define ADCRI_CTRL_START 7
`define ADCRI_CTRL_BUSY 6
`define ADCRI_CTRL_EN 5
`define ADCRI_CTRL_FMT 4
// Trigger register fields
`define ADCRI_TRIG_PATH 7
`define ADCRI_TRIG_DLEN 6
`define ADCRI_TRIG_PWIS 5

// Writable masks (reserved bits read zero)
`define ADCRI_SRC_MASK 8'he7
`define ADCRI_REF_MASK 8'h9f
`define ADCRI_TRIG_MASK 8'hfb
`define ADCRI_BGAP_MASK 8'h01

// Reset values
`define ADCRI_RST_BYTE 8'h00

// Highest external channel code that routes a pin
`define ADCRI_CH_MAX 4'h8
// First code connecting nothing
`define ADCRI_CH_FLOAT 4'hb

// Conversion time as a figure in ns and in system clock cycles
`define ADCRI_CLK_NS 10
`define ADCRI_CONV_NS 160
`define ADCRI_CONV_CYC ((`ADCRI_CONV_NS + `ADCRI_CLK_NS - 1) / `ADCRI_CLK_NS)

// Interrupt status bits
`define ADCRI_IRQ_DONE 0
`define ADCRI_IRQ_BOUND 1

`endif

// file: logic/adcri_pkg.sv
// Types shared by the converter register block.
// Assumes the constants header is on the include path.
`include "adcri_consts.svh"

package adcri_pkg;

	typedef enum logic [1:0] {
		ADCRI_IDLE,
		ADCRI_DELAY,
		ADCRI_CONV
	} adcri_phase_t;

	// Core-side request and result
	typedef struct packed {
		logic power_on;
		logic sample;
		logic [3:0] ext_channel_select;
		logic [2:0] input_source_select;
	} adcri_core_req_t;

	typedef struct packed {
		logic done;
		logic [11:0] value;
	} adcri_core_rsp_t;

	// Whole state of the register block
	typedef struct packed {
		logic [11:0] result;
		logic [11:0] lower_limit;
		logic [11:0] upper_limit;
		logic [7:0] conversion_control;
		logic [7:0] source_clock_select;
		logic [7:0] reference_gain_select;
		logic [7:0] trigger_compare_control;
		logic [7:0] start_delay_count;
		logic [7:0] bandgap_enable_control;
		logic [1:0] irq_status;
		logic [1:0] irq_enable;
		adcri_phase_t phase;
		logic [7:0] count;
		logic pwm_prev;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic irq;
		adcri_core_req_t core;
		logic [8:0] pin_analog;
		logic ext_floating;
	} adcri_state_t;

endpackage

// file: testbench/tb.sv
// Self-checking bench for the converter register block, driven over APB.
// Assumes the design package and constants header are compiled first.
`timescale 1ns/1ps

`include "adcri_consts.svh"

`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
	$display("FAIL t=%0t got %h exp %h", $time, g, e); end end

module tb
	import adcri_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, pready, pslverr, irq, ext_floating, err, pwm_p, pwm_d;
	logic [11:0] paddr, v;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [8:0] pin_assign, pins;
	adcri_core_req_t core_req;
	adcri_core_rsp_t core_rsp;
	int n_errors, samples_checked, cnt;
	int seed = 43;

	adcri_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .core_req(core_req), .core_rsp(core_rsp),
		.pwm_period_match_flag(pwm_p), .pwm_duty_match_flag(pwm_d),
		.analog_pin_assign(pin_assign), .analog_input_pins(pins),
		.ext_floating(ext_floating), .irq(irq));

	// 100 MHz clock
	always #5 pclk = ~pclk;

	// Expected byte layout of a 12-bit value
	function automatic logic [7:0] exp_hi(input logic fmt, input logic [11:0] x);
		return fmt ? {4'h0, x[11:8]} : x[11:4];
	endfunction
	function automatic logic [7:0] exp_lo(input logic fmt, input logic [11:0] x);
		return fmt ? x[7:0] : {x[3:0], 4'h0};
	endfunction

	// One APB transfer; holds the request until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) n_errors++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Read a register and compare its byte
	task automatic rchk(input logic [11:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h00);
		`CHK(rd, {24'h000000, e})
	endtask

	// Start-bit conversion with a given result value
	task automatic conv(input logic fmt, input logic [11:0] val);
		int n;
		apb(1'b1, `ADCRI_OFF_CTRL, {3'b101, fmt, 4'h0});
		apb(1'b1, `ADCRI_OFF_CTRL, {3'b001, fmt, 4'h0});
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (core_req.sample !== 1'b1 && n < 20);
		`CHK(n < 20, 1'b1)
		rchk(`ADCRI_OFF_CTRL, {3'b011, fmt, 4'h0});
		core_rsp <= {1'b1, val};
		@(posedge pclk);
		core_rsp.done <= 1'b0;
		rchk(`ADCRI_OFF_CTRL, {3'b001, fmt, 4'h0});
		rchk(`ADCRI_OFF_RES_HI, exp_hi(fmt, val));
		rchk(`ADCRI_OFF_RES_LO, exp_lo(fmt, val));
	endtask

	// Verdict and end of run
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge pclk);
		n_errors++;
		tally_and_finish();
	end

	// Main sequence
	initial begin
		{presetn, psel, penable, pwrite, pwm_p, pwm_d} = 6'h00;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		pstrb = 4'hf;
		pin_assign = 9'h000;
		core_rsp = '0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rchk(`ADCRI_OFF_CTRL, 8'h00);
		rchk(`ADCRI_OFF_TRIG, 8'h00);
		rchk(`ADCRI_OFF_DELAY, 8'h00);
		pstrb <= 4'he;
		apb(1'b1, `ADCRI_OFF_DELAY, 8'h77);
		pstrb <= 4'hf;
		rchk(`ADCRI_OFF_DELAY, 8'h00);
		apb(1'b0, 12'h03c, 8'h00);
		`CHK({err, rd}, 33'h100000000)
		$display("test reset done");
		// Busy position is read-only; enable powers the core
		apb(1'b1, `ADCRI_OFF_CTRL, 8'h60);
		rchk(`ADCRI_OFF_CTRL, 8'h20);
		`CHK(core_req.power_on, 1'b1)
		// Limits 0x100 and 0xeff in format 0
		apb(1'b1, `ADCRI_OFF_LLIM_HI, 8'h10);
		apb(1'b1, `ADCRI_OFF_LLIM_LO, 8'h00);
		apb(1'b1, `ADCRI_OFF_ULIM_HI, 8'hef);
		apb(1'b1, `ADCRI_OFF_ULIM_LO, 8'hf0);
		rchk(`ADCRI_OFF_ULIM_LO, 8'hf0);
		apb(1'b1, `ADCRI_OFF_IRQ_EN, 8'h03);
		for (int i = 0; i < 8; i++) begin
			v = 12'h101 + 12'($unsigned($random(seed)) % 32'hdfd);
			conv(i[0], v);
			`CHK(irq, 1'b1)
			rchk(`ADCRI_OFF_IRQ_STAT, 8'h01);
			apb(1'b1, `ADCRI_OFF_IRQ_CLR, 8'h03);
			rchk(`ADCRI_OFF_IRQ_STAT, 8'h00);
			`CHK(irq, 1'b0)
		end
		rchk(`ADCRI_OFF_LLIM_HI, 8'h01);
		// Boundary values outside the limits; then masked
		conv(1'b0, 12'hfff);
		rchk(`ADCRI_OFF_IRQ_STAT, 8'h03);
		apb(1'b1, `ADCRI_OFF_IRQ_CLR, 8'h03);
		apb(1'b1, `ADCRI_OFF_IRQ_EN, 8'h00);
		conv(1'b1, 12'h0a5);
		`CHK(irq, 1'b0)
		rchk(`ADCRI_OFF_IRQ_STAT, 8'h03);
		$display("test conversions done");
		// Disabled: contents held, start ignored
		apb(1'b1, `ADCRI_OFF_CTRL, 8'h10);
		apb(1'b1, `ADCRI_OFF_LLIM_HI, 8'h05);
		rchk(`ADCRI_OFF_LLIM_HI, 8'h01);
		apb(1'b1, `ADCRI_OFF_CTRL, 8'h90);
		apb(1'b1, `ADCRI_OFF_CTRL, 8'h10);
		rchk(`ADCRI_OFF_CTRL, 8'h10);
		core_rsp <= {1'b1, 12'h3c3};
		@(posedge pclk);
		core_rsp.done <= 1'b0;
		rchk(`ADCRI_OFF_RES_LO, 8'ha5);
		`CHK(core_req.power_on, 1'b0)
		$display("test disable done");
		// Every channel code with the external source
		for (int i = 0; i < 16; i++) begin
			pin_assign <= i[0] ? 9'h1ff : 9'($random(seed));
			apb(1'b1, `ADCRI_OFF_CTRL, {4'h2, 4'(i)});
			repeat (2) @(posedge pclk);
			`CHK(core_req.ext_channel_select, 4'(i))
			`CHK(pins, (i <= 8) ? ((9'h001 << i) & pin_assign) : 9'h000)
			if (i <= 8 || i >= 11) `CHK(ext_floating, (i >= 11))
		end
		// Internal source cuts the external channel
		apb(1'b1, `ADCRI_OFF_CTRL, 8'h23);
		apb(1'b1, `ADCRI_OFF_SRC, 8'h20);
		repeat (2) @(posedge pclk);
		`CHK({pins, ext_floating, core_req.input_source_select}, 13'h001)
		apb(1'b1, `ADCRI_OFF_SRC, 8'h00);
		$display("test channels done");
		// Delayed path: start bit ignored, period then duty flag rise starts after delay
		for (int k = 0; k < 2; k++) begin
			apb(1'b1, `ADCRI_OFF_CTRL, 8'h20);
			apb(1'b1, `ADCRI_OFF_TRIG, {2'b11, k[0], 5'h00});
			apb(1'b1, `ADCRI_OFF_DELAY, 8'h05);
			apb(1'b1, `ADCRI_OFF_CTRL, 8'ha0);
			apb(1'b1, `ADCRI_OFF_CTRL, 8'h20);
			rchk(`ADCRI_OFF_CTRL, 8'h20);
			{pwm_d, pwm_p} <= k[0] ? 2'b10 : 2'b01;
			v = 12'($random(seed));
			cnt = 0;
			do begin
				@(posedge pclk);
				cnt++;
			end while (core_req.sample !== 1'b1 && cnt < 40);
			`CHK((cnt >= 5 && cnt <= 9), 1'b1)
			core_rsp <= {1'b1, v};
			@(posedge pclk);
			core_rsp.done <= 1'b0;
			{pwm_d, pwm_p} <= 2'b00;
			rchk(`ADCRI_OFF_RES_HI, exp_hi(1'b0, v));
		end
		apb(1'b1, `ADCRI_OFF_TRIG, 8'h00);
		$display("test delayed start done");
		tally_and_finish();
	end
endmodule
